// >>> core/ptr_pkg.sv
package ptr_pkg;

  // Register word offsets (byte addresses on the Avalon-MM slave).
  localparam logic [3:0] REG_ROUTE_CTRL = 4'h0;
  localparam logic [3:0] REG_ADC_MODE0 = 4'h4;
  localparam logic [3:0] REG_ADC_MODE1 = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // Route control field positions.
  localparam int CAP0_EN_BIT = 0;
  localparam int CAP1_EN_BIT = 1;
  localparam int SYNC_EN_BIT = 2;
  localparam int UCLK_EN_LSB = 4;
  localparam int CARR_EN_LSB = 8;
  localparam int S3_GROUP_LSB = 12;
  localparam int DS_SYNC_EN_BIT = 16;
  localparam logic [31:0] ROUTE_RESET = 32'h0000_1000;

  // ADC mode field positions.
  localparam int SCAN_EN_BIT = 0;
  localparam int CHSEL_LSB = 0;
  localparam int SCANLEN_LSB = 4;
  localparam logic [3:0] LAST_CHANNEL = 4'h3;
  localparam logic [1:0] SCANLEN_RESERVED = 2'h3;

  // Pin group choice for serial channel 3.
  localparam logic [1:0] S3_GROUP_A = 2'h1;
  localparam logic [1:0] S3_GROUP_B = 2'h2;

  typedef enum logic [1:0] {
    ADC_IDLE = 2'b00,
    ADC_CONV = 2'b01,
    ADC_NEXT = 2'b10
  } ptr_adc_state_t;

  typedef struct packed {
    logic [6:0] timerOut;
    logic eventStart0;
    logic dsStart0;
  } ptr_src_t;

  typedef struct packed {
    logic [1:0] captureTrig;
    logic eventSyncStart;
    logic [3:0] uartClk;
    logic [2:0] carrier;
    logic [1:0] dsSlaveStart;
  } ptr_dst_t;

endpackage

// >>> core/ptr_router.sv
`timescale 1ns/100ps
module ptr_router (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  output logic [1:0] avsResponse,
  input wire ptr_pkg::ptr_src_t src,
  output ptr_pkg::ptr_dst_t dst,
  output logic [6:0] timerPinOut,
  output logic [6:0] timerMatchIrqEn,
  output logic s3GroupAEn,
  output logic s3GroupBEn,
  output logic s3GroupError,
  output logic [1:0] adcMuxSel,
  output logic adcConvStart,
  input wire logic adcConvDone,
  output logic adcBusy,
  output logic adcSettingError
);

  logic [31:0] route_q;
  logic [31:0] mode0_q;
  logic [31:0] mode1_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic [1:0] capTrig_q;
  logic syncStart_q;
  logic [3:0] uartClk_q;
  logic [2:0] carrier_q;
  logic [1:0] dsSlave_q;
  ptr_pkg::ptr_dst_t dst_d;
  ptr_pkg::ptr_adc_state_t adcState_q;
  logic [1:0] adcCh_q;
  logic startReq_q;
  logic startPulse_q;
  logic [1:0] timerGate;
  logic [3:0] chField;
  logic [1:0] scanLen;
  logic scanOn;
  logic access;
  logic mapped;
  logic [31:0] statusWord;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [3:0] addr);
    return addr == ptr_pkg::REG_ROUTE_CTRL || addr == ptr_pkg::REG_ADC_MODE0
      || addr == ptr_pkg::REG_ADC_MODE1 || addr == ptr_pkg::REG_STATUS;
  endfunction

  assign access = (avsRead || avsWrite) && clkEn;
  assign mapped = is_mapped(avsAddress);
  // One wait cycle per access: the answer stands at the edge after ack.
  assign avsWaitRequest = !ack_q;
  assign avsReadData = rdata_q;
  assign avsResponse = resp_q;

  assign chField = mode1_q[ptr_pkg::CHSEL_LSB +: 4];
  assign scanLen = mode1_q[ptr_pkg::SCANLEN_LSB +: 2];
  assign scanOn = mode0_q[ptr_pkg::SCAN_EN_BIT];

  // The device cannot stop software writing unusable codes, so it flags them.
  assign adcSettingError = (chField > ptr_pkg::LAST_CHANNEL)
    || (scanOn && scanLen == ptr_pkg::SCANLEN_RESERVED);

  assign s3GroupAEn = route_q[ptr_pkg::S3_GROUP_LSB +: 2]
    == ptr_pkg::S3_GROUP_A;
  assign s3GroupBEn = route_q[ptr_pkg::S3_GROUP_LSB +: 2]
    == ptr_pkg::S3_GROUP_B;
  assign s3GroupError = !(s3GroupAEn || s3GroupBEn);

  assign statusWord = {26'h0, adcSettingError, s3GroupError, adcCh_q,
    adcState_q};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      resp_q <= 2'h0;
    end else if (clkEn) begin
      ack_q <= access && !ack_q;
      if (access && !ack_q) begin
        resp_q <= mapped ? 2'h0 : 2'h2;
        case (avsAddress)
          ptr_pkg::REG_ROUTE_CTRL: rdata_q <= route_q;
          ptr_pkg::REG_ADC_MODE0: rdata_q <= mode0_q;
          ptr_pkg::REG_ADC_MODE1: rdata_q <= mode1_q;
          ptr_pkg::REG_STATUS: rdata_q <= statusWord;
          default: rdata_q <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      route_q <= ptr_pkg::ROUTE_RESET;
      mode0_q <= 32'h0;
      mode1_q <= 32'h0;
    end else if (clkEn && avsWrite && ack_q) begin
      case (avsAddress)
        ptr_pkg::REG_ROUTE_CTRL: begin
          route_q <= merge_bytes(route_q, avsWriteData, avsByteEnable);
        end
        ptr_pkg::REG_ADC_MODE0: begin
          mode0_q <= merge_bytes(mode0_q, avsWriteData, avsByteEnable);
        end
        ptr_pkg::REG_ADC_MODE1: begin
          mode1_q <= merge_bytes(mode1_q, avsWriteData, avsByteEnable);
        end
        default: begin
        end
      endcase
    end
  end

  // A write with bit 1 of mode register 0 requests one conversion run.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      startReq_q <= 1'b0;
    end else if (clkEn) begin
      startReq_q <= avsWrite && ack_q && avsByteEnable[0]
        && avsAddress == ptr_pkg::REG_ADC_MODE0 && avsWriteData[1];
    end
  end

  // Every route is an AND of its enable and its source, so a disabled
  // route can never leak a stray edge into the receiving block.
  function automatic logic gate_route(input logic en, input logic sig);
    return en && sig;
  endfunction

  always_comb begin
    timerGate = {src.timerOut[1], src.timerOut[0]};
    dst_d = '0;
    dst_d.captureTrig[0] = gate_route(route_q[ptr_pkg::CAP0_EN_BIT],
      src.timerOut[3]);
    dst_d.captureTrig[1] = gate_route(route_q[ptr_pkg::CAP1_EN_BIT],
      src.timerOut[6]);
    dst_d.eventSyncStart = gate_route(route_q[ptr_pkg::SYNC_EN_BIT],
      src.eventStart0);
    dst_d.uartClk[0] = gate_route(route_q[ptr_pkg::UCLK_EN_LSB],
      timerGate[0]);
    dst_d.uartClk[1] = gate_route(route_q[ptr_pkg::UCLK_EN_LSB + 1],
      timerGate[0]);
    dst_d.uartClk[2] = gate_route(route_q[ptr_pkg::UCLK_EN_LSB + 2],
      timerGate[1]);
    dst_d.uartClk[3] = gate_route(route_q[ptr_pkg::UCLK_EN_LSB + 3],
      timerGate[1]);
    dst_d.carrier[0] = gate_route(route_q[ptr_pkg::CARR_EN_LSB],
      src.timerOut[4]);
    dst_d.carrier[1] = gate_route(route_q[ptr_pkg::CARR_EN_LSB + 1],
      src.timerOut[4]);
    dst_d.carrier[2] = gate_route(route_q[ptr_pkg::CARR_EN_LSB + 2],
      src.timerOut[4]);
    dst_d.dsSlaveStart[0] = gate_route(route_q[ptr_pkg::DS_SYNC_EN_BIT],
      src.dsStart0);
    dst_d.dsSlaveStart[1] = gate_route(route_q[ptr_pkg::DS_SYNC_EN_BIT],
      src.dsStart0);
  end

  // One register per destination group; each is the single stage of
  // latency that a route adds.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      capTrig_q <= 2'h0;
    end else if (clkEn) begin
      capTrig_q <= dst_d.captureTrig;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncStart_q <= 1'b0;
    end else if (clkEn) begin
      syncStart_q <= dst_d.eventSyncStart;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uartClk_q <= 4'h0;
    end else if (clkEn) begin
      uartClk_q <= dst_d.uartClk;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carrier_q <= 3'h0;
    end else if (clkEn) begin
      carrier_q <= dst_d.carrier;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dsSlave_q <= 2'h0;
    end else if (clkEn) begin
      dsSlave_q <= dst_d.dsSlaveStart;
    end
  end

  // Event timer 1 follows the start of event timer 0 through one fixed
  // register stage, so both run in lockstep once the route is on.
  assign dst = {capTrig_q, syncStart_q, uartClk_q, carrier_q,
    dsSlave_q};

  // Timer 4 has no pin and no match interrupt; the others pass straight on.
  assign timerPinOut = src.timerOut & 7'h6f;
  assign timerMatchIrqEn = 7'h6f;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adcState_q <= ptr_pkg::ADC_IDLE;
      adcCh_q <= 2'h0;
      startPulse_q <= 1'b0;
    end else if (clkEn) begin
      startPulse_q <= 1'b0;
      case (adcState_q)
        ptr_pkg::ADC_IDLE: begin
          if (startReq_q && !adcSettingError) begin
            // Fixed mode takes the field; scan begins at channel 0.
            adcCh_q <= scanOn ? 2'h0 : chField[1:0];
            startPulse_q <= 1'b1;
            adcState_q <= ptr_pkg::ADC_CONV;
          end
        end
        ptr_pkg::ADC_CONV: begin
          if (adcConvDone) begin
            adcState_q <= ptr_pkg::ADC_NEXT;
          end
        end
        ptr_pkg::ADC_NEXT: begin
          // Scan length does not change the range: the field sets the end.
          if (scanOn && adcCh_q != chField[1:0]) begin
            adcCh_q <= adcCh_q + 2'h1;
            startPulse_q <= 1'b1;
            adcState_q <= ptr_pkg::ADC_CONV;
          end else begin
            adcState_q <= ptr_pkg::ADC_IDLE;
          end
        end
        default: adcState_q <= ptr_pkg::ADC_IDLE;
      endcase
    end
  end

  // Mux codes: 0 pin 0, 1 pin 1, 2 temperature sensor, 3 bandgap.
  assign adcMuxSel = adcCh_q;
  assign adcConvStart = startPulse_q;
  assign adcBusy = adcState_q != ptr_pkg::ADC_IDLE;

endmodule

// >>> verification/ptr_router_assertions.sv
`timescale 1ns/100ps
module ptr_router_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ptr_pkg::ptr_src_t src,
  input wire ptr_pkg::ptr_dst_t dst,
  input wire logic [6:0] timerPinOut,
  input wire logic [6:0] timerMatchIrqEn,
  input wire logic [1:0] adcMuxSel,
  input wire logic adcConvStart,
  input wire logic adcConvDone,
  input wire logic adcBusy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence sConvWait;
    adcConvStart ##1 !adcConvDone;
  endsequence
  AST_CAP0: assert property (
    dst.captureTrig[0] |-> $past(src.timerOut[3])) else $error("cap0");
  AST_CAP1: assert property (
    dst.captureTrig[1] |-> $past(src.timerOut[6])) else $error("cap1");
  AST_SYNC: assert property (
    dst.eventSyncStart |-> $past(src.eventStart0)) else $error("sync");
  AST_UCLK: assert property (
    (!(|dst.uartClk[1:0]) || $past(src.timerOut[0])) &&
    (!(|dst.uartClk[3:2]) || $past(src.timerOut[1]))) else $error("uclk");
  AST_CARR: assert property (
    |dst.carrier |-> $past(src.timerOut[4])) else $error("carrier");
  AST_DS: assert property (
    |dst.dsSlaveStart |-> $past(src.dsStart0)) else $error("ds start");
  AST_PIN4: assert property (
    !timerPinOut[4] && !timerMatchIrqEn[4]) else $error("timer 4 pin");
  AST_START: assert property (
    adcConvStart |=> !adcConvStart && adcBusy) else $error("start");
  AST_MUXHOLD: assert property (
    sConvWait |-> $stable(adcMuxSel)) else $error("mux moved");
endmodule
bind ptr_router ptr_router_chk chk (.ref_clk, .rst, .src, .dst, .timerPinOut,
  .timerMatchIrqEn, .adcMuxSel, .adcConvStart, .adcConvDone, .adcBusy);

// >>> verification/ptr_conv_model.sv
`timescale 1ns/100ps
module ptr_conv_model #(
  parameter int LAT = 3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic adcConvStart,
  output logic adcConvDone
);
  // One done pulse per start; a new start restarts the count.
  int cnt;
  always_ff @(posedge ref_clk) begin
    if (rst || adcConvStart) begin
      cnt <= rst ? 0 : LAT;
      adcConvDone <= 1'b0;
    end else begin
      cnt <= (cnt != 0) ? cnt - 1 : 0;
      adcConvDone <= (cnt == 1);
    end
  end
endmodule

// >>> verification/ptr_router_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ptr_router_tb;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic avsRead = 1'h0;
  logic avsWrite = 1'h0;
  logic [3:0] avsAddress = 4'h0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData, rdata;
  logic avsWaitRequest, s3A, s3B, s3Err, adcConvStart, done, adcBusy, aErr;
  logic [1:0] avsResponse, resp, adcMuxSel;
  logic [6:0] pins, irqEn;
  ptr_pkg::ptr_src_t src = '0;
  ptr_pkg::ptr_dst_t dst, ex;
  int error_cnt = 0;
  int n_checks = 0;
  always #10 ref_clk = ~ref_clk;
  ptr_router uut (.ref_clk(ref_clk), .rst(rst), .clkEn(1'h1),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(4'hf),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .avsResponse(avsResponse), .src(src), .dst(dst), .timerPinOut(pins),
    .timerMatchIrqEn(irqEn), .s3GroupAEn(s3A), .s3GroupBEn(s3B),
    .s3GroupError(s3Err), .adcMuxSel(adcMuxSel), .adcConvStart(adcConvStart),
    .adcConvDone(done), .adcBusy(adcBusy), .adcSettingError(aErr));
  ptr_conv_model conv_m (.ref_clk(ref_clk), .rst(rst),
    .adcConvStart(adcConvStart), .adcConvDone(done));
  task summarize;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge ref_clk); while (avsWaitRequest !== 1'b0);
    rdata = avsReadData;
    resp = avsResponse;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge ref_clk);
  endtask
  task route(input int i, input logic on);
    ptr_pkg::ptr_src_t s;
    s = '0;
    if (i < 7) s.timerOut[i] = 1'b1;
    s.eventStart0 = (i == 7);
    s.dsStart0 = (i == 8);
    ex.captureTrig = {s.timerOut[6], s.timerOut[3]};
    ex.eventSyncStart = s.eventStart0;
    ex.uartClk = {{2{s.timerOut[1]}}, {2{s.timerOut[0]}}};
    ex.carrier = {3{s.timerOut[4]}};
    ex.dsSlaveStart = {2{s.dsStart0}};
    if (!on) ex = '0;
    src <= s;
    @(posedge ref_clk);
    @(posedge ref_clk);
    `CHK("dst", ex, dst)
    `CHK("pin4", 1'h0, pins[4])
  endtask
  task start(input logic [31:0] m1, input logic [31:0] m0);
    do @(posedge ref_clk); while (adcBusy !== 1'b0);
    bus(1, ptr_pkg::REG_ADC_MODE1, m1);
    bus(1, ptr_pkg::REG_ADC_MODE0, m0);
  endtask
  task conv(input logic [1:0] ch);
    do @(posedge ref_clk); while (adcConvStart !== 1'b1);
    `CHK("mux", ch, adcMuxSel)
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    bus(0, ptr_pkg::REG_ROUTE_CTRL, 32'h0);
    `CHK("route", ptr_pkg::ROUTE_RESET, rdata)
    `CHK("grp", 3'h4, {s3A, s3B, s3Err})
    `CHK("irq", 7'h6f, irqEn)
    bus(0, 4'h2, 32'h0);
    `CHK("unmapped", 34'h2_0000_0000, {resp, rdata})
    for (int i = 0; i < 9; i++) route(i, 1'b0);
    bus(1, ptr_pkg::REG_ROUTE_CTRL, 32'h0001_27f7);
    `CHK("grp", 3'h2, {s3A, s3B, s3Err})
    for (int i = 0; i < 9; i++) route(i, 1'b1);
    bus(1, ptr_pkg::REG_ROUTE_CTRL, 32'h0);
    `CHK("grp", 3'h1, {s3A, s3B, s3Err})
    start(32'h2, 32'h2);
    conv(2'h2);
    // Scan end rises with the length here: each run checks channels 0 up to its field end.
    for (int l = 0; l < 3; l++) begin
      start(32'(l * 17 + 1), 32'h3);
      for (int c = 0; c <= l + 1; c++) conv(2'(c));
    end
    start(32'h4, 32'h0);
    `CHK("bad code", 1'h1, aErr)
    summarize();
  end
endmodule
